/* File: ecp_port_defs.svh */
`ifndef ECP_PORT_DEFS_SVH
`define ECP_PORT_DEFS_SVH

`define OFS_DATA 11'h000
`define OFS_DSR 11'h001
`define OFS_DCR 11'h002
`define OFS_FIFO 11'h400
`define OFS_CFGB 11'h401
`define OFS_ECR 11'h402
`define OFS_IRQ_STATUS 11'h403
`define OFS_IRQ_MASK 11'h404

`define MODE_SPP 3'h0
`define MODE_PS2 3'h1
`define MODE_COMPAT 3'h2
`define MODE_ECP 3'h3
`define MODE_TEST 3'h6
`define MODE_CONFIG 3'h7

`define CFGA_VALUE 8'h10
`define DCR_RESET 6'h04
`define MODE_RESET 3'h0
`define ERRN_RESET 1'b1
`define MASK_RESET 3'h0
`define SYNC_IDLE 13'h0500

`define DCR_STROBE 0
`define DCR_AUTOFD 1
`define DCR_INIT 2
`define DCR_SELECT 3
`define DCR_ACKIRQ 4
`define DCR_DIR 5

`define IRQ_FAULT 0
`define IRQ_SERVICE 1
`define IRQ_ACK 2

`define ADDR_FLAG_BIT 7
`define TAG_BIT 8

`define SETUP_NS 80
`define CLK_NS 40
`define SETUP_CYCLES ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: ecp_port_pkg.sv */
package ecp_port_pkg;
	typedef enum logic [2:0] {
		L_IDLE,
		L_SETUP,
		L_STROBE,
		L_HOLD,
		L_REV_WAIT,
		L_REV_ACK
	} link_state_t;
endpackage : ecp_port_pkg

/* File: ecp_port.sv */
// Summary of operation
// - port word is always eight bits
// - all fifo views share one 16-byte buffer
// - dma burst channel, forward or reverse
// - expand run-length count into repeated bytes
// - compression optional, not provided here
// - compat mode strobes bytes out automatically
// - forward byte strobed, interlocked with peripheral
// - reverse bytes tagged command or data
// - status, control reachable in every mode; data too, but ecp mode data writes go to the address fifo
// - config b reports assigned irq and dma
// - address fifo bytes queued tagged, forward only
// - status low three bits read zero
`timescale 1ns/10ps
`include "ecp_port_defs.svh"

module ecp_port
	import ecp_port_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int PTR_W = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [10:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] irq_select,
	input wire logic [2:0] dma_select,
	output logic dma_req,
	output logic irq,
	input wire logic [7:0] parallel_data_lines_in,
	output logic [7:0] parallel_data_lines_out,
	output logic parallel_data_lines_oe,
	output logic host_clock_strobe_n,
	output logic host_handshake_line_n,
	output logic direction_request_line_n,
	output logic select_in_line_n,
	input wire logic periph_clock_line_n,
	input wire logic periph_handshake,
	input wire logic periph_fault_line_n,
	input wire logic paper_error_line,
	input wire logic select_line
);

	if (DEPTH != (1 << PTR_W) || PTR_W < 1 || PTR_W > 8) begin : depth_chk
		$error("fifo depth must be two to the pointer width");
	end

	typedef struct packed {
		logic [12:0] sync1;
		logic [12:0] sync2;
		logic fault_q, ack_q, svc_q, err_en_n, dma_en, run_pending, pd_en;
		logic strobe_n, autofd_n, init_n, selin_n;
		logic [7:0] data_reg, rep_left, rep_byte, rdata, pd_o;
		logic [5:0] dcr;
		logic [2:0] mode, irq_status, irq_mask, timer;
		logic [DEPTH-1:0][8:0] mem;
		logic [PTR_W-1:0] wr_ptr, rd_ptr;
		logic [PTR_W:0] count;
		link_state_t link;
		logic [8:0] out_entry;
		logic [6:0] run_count;
	} state_t;

	state_t s, n;

	logic [7:0] pd_s;
	logic ack_n_s, busy_s, fault_n_s, paper_error_line_s, select_s;
	logic fifo_full, fifo_empty, link_mode, fwd;
	logic push, pop, flush, clr_status, svc_cond;
	logic [8:0] push_data;
	logic [2:0] set_bits;

	function automatic logic is_link_mode(input logic [2:0] m);
		return m == `MODE_COMPAT || m == `MODE_ECP;
	endfunction : is_link_mode

	// only the second stage is ever read
	assign {select_s, paper_error_line_s, fault_n_s, busy_s, ack_n_s, pd_s} = s.sync2;

	assign fifo_full = s.count == (PTR_W+1)'(DEPTH);
	assign fifo_empty = s.count == '0;
	assign link_mode = is_link_mode(s.mode);
	assign fwd = !s.dcr[`DCR_DIR];

	assign dma_req = s.dma_en && link_mode
		&& (fwd ? !fifo_full : !fifo_empty);
	assign irq = |(s.irq_status & s.irq_mask);
	assign svc_cond = !s.dma_en && link_mode
		&& (fwd ? fifo_empty : !fifo_empty);

	always_comb begin
		n = s;
		push = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		push_data = '0;
		clr_status = 1'b0;
		n.sync1 = {select_line, paper_error_line, periph_fault_line_n,
			periph_handshake, periph_clock_line_n, parallel_data_lines_in};
		n.sync2 = s.sync1;
		n.fault_q = fault_n_s;
		n.ack_q = ack_n_s;
		n.svc_q = svc_cond;
		n.rdata = 8'h00;

		if (reg_wr) begin
			unique case (reg_addr)
				`OFS_DATA: begin
					if (s.mode == `MODE_ECP) begin
						// forward only; ignored in reverse or when full
						if (fwd && !fifo_full) begin
							push = 1'b1;
							push_data = {1'b1, reg_wdata};
						end
					end else begin
						n.data_reg = reg_wdata;
					end
				end
				`OFS_DCR: n.dcr = reg_wdata[5:0];
				`OFS_FIFO: begin
					if (((link_mode && fwd) || s.mode == `MODE_TEST)
						&& !fifo_full) begin
						push = 1'b1;
						push_data = {1'b0, reg_wdata};
					end
				end
				`OFS_ECR: begin
					n.mode = reg_wdata[7:5];
					n.err_en_n = reg_wdata[4];
					n.dma_en = reg_wdata[3];
					flush = reg_wdata[7:5] == `MODE_SPP
						|| reg_wdata[7:5] == `MODE_PS2;
				end
				`OFS_IRQ_MASK: n.irq_mask = reg_wdata[2:0];
				default: ;
			endcase
		end

		if (reg_rd) begin
			unique case (reg_addr)
				`OFS_DATA: n.rdata = pd_s;
				`OFS_DSR: n.rdata = {!busy_s, ack_n_s, paper_error_line_s, select_s,
					fault_n_s, 3'h0};
				`OFS_DCR: n.rdata = {2'h0, s.dcr};
				`OFS_FIFO: begin
					if (s.mode == `MODE_CONFIG) begin
						n.rdata = `CFGA_VALUE;
					end else if (((s.mode == `MODE_ECP && !fwd)
						|| s.mode == `MODE_TEST) && !fifo_empty) begin
						pop = 1'b1;
						n.rdata = s.mem[s.rd_ptr][7:0];
					end
				end
				// compress bit stays low: no hardware compression
				`OFS_CFGB: n.rdata = {1'b0, irq, irq_select,
					dma_select};
				`OFS_ECR: n.rdata = {s.mode, s.err_en_n, s.dma_en,
					s.irq_status[`IRQ_SERVICE], fifo_full,
					fifo_empty};
				`OFS_IRQ_STATUS: begin
					n.rdata = {5'h00, s.irq_status};
					clr_status = 1'b1;
				end
				`OFS_IRQ_MASK: n.rdata = {5'h00, s.irq_mask};
				default: ;
			endcase
		end

		unique case (s.link)
			L_IDLE: begin
				if (link_mode && fwd) begin
					if (!fifo_empty && !busy_s) begin
						pop = 1'b1;
						n.out_entry = s.mem[s.rd_ptr];
						n.timer = 3'(`SETUP_CYCLES);
						n.link = L_SETUP;
					end
				end else if (s.mode == `MODE_ECP && !fwd && !fifo_full
					&& s.rep_left == 8'h00) begin
					n.link = L_REV_WAIT;
				end
			end
			// data settles on the lines before the strobe falls
			L_SETUP: begin
				if (s.timer <= 3'h1) begin
					n.link = L_STROBE;
				end else begin
					n.timer = s.timer - 3'h1;
				end
			end
			L_STROBE: begin
				if (busy_s) begin
					n.link = L_HOLD;
				end
			end
			L_HOLD: begin
				if (!busy_s) begin
					n.link = L_IDLE;
				end
			end
			L_REV_WAIT: begin
				if (s.mode != `MODE_ECP || fwd) begin
					n.link = L_IDLE;
				end else if (!ack_n_s) begin
					n.link = L_REV_ACK;
					if (!busy_s && !pd_s[`ADDR_FLAG_BIT]) begin
						n.run_count = pd_s[6:0];
						n.run_pending = 1'b1;
					end else if (busy_s && s.run_pending) begin
						n.rep_left = {1'b0, s.run_count} + 8'h01;
						n.rep_byte = pd_s;
						n.run_pending = 1'b0;
					end else begin
						push = 1'b1;
						push_data = {!busy_s, pd_s};
					end
				end
			end
			L_REV_ACK: begin
				if (ack_n_s) begin
					n.link = L_IDLE;
				end
			end
			default: n.link = L_IDLE;
		endcase

		// a run is written one byte a cycle as room appears
		if (s.rep_left != 8'h00 && !fifo_full && !push) begin
			push = 1'b1;
			push_data = {1'b0, s.rep_byte};
			n.rep_left = s.rep_left - 8'h01;
		end

		if (push) begin
			n.mem[s.wr_ptr] = push_data;
			n.wr_ptr = s.wr_ptr + 1'b1;
		end
		if (pop) begin
			n.rd_ptr = s.rd_ptr + 1'b1;
		end
		n.count = s.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		if (flush) begin
			n.count = '0;
			n.wr_ptr = '0;
			n.rd_ptr = '0;
			n.link = L_IDLE;
			n.rep_left = 8'h00;
			n.run_pending = 1'b0;
		end

		// set wins over the read clear
		set_bits = 3'h0;
		set_bits[`IRQ_FAULT] = s.fault_q && !fault_n_s && !s.err_en_n;
		set_bits[`IRQ_SERVICE] = svc_cond && !s.svc_q;
		set_bits[`IRQ_ACK] = !s.ack_q && ack_n_s && s.dcr[`DCR_ACKIRQ];
		n.irq_status = (clr_status ? 3'h0 : s.irq_status) | set_bits;

		if (is_link_mode(n.mode)) begin
			n.strobe_n = n.link != L_STROBE;
			n.pd_o = n.out_entry[7:0];
		end else begin
			n.strobe_n = !n.dcr[`DCR_STROBE];
			n.pd_o = n.data_reg;
		end
		if (n.mode == `MODE_ECP) begin
			// low marks a command byte going out; in reverse, ready
			n.autofd_n = n.dcr[`DCR_DIR] ? n.link != L_REV_WAIT
				: !n.out_entry[`TAG_BIT];
			n.init_n = !n.dcr[`DCR_DIR];
			n.selin_n = 1'b1;
		end else begin
			n.autofd_n = !n.dcr[`DCR_AUTOFD];
			n.init_n = n.dcr[`DCR_INIT];
			n.selin_n = !n.dcr[`DCR_SELECT];
		end
		n.pd_en = !n.dcr[`DCR_DIR] || n.mode == `MODE_SPP;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
			// idle pin levels, so no false edge follows reset
			s.sync1 <= `SYNC_IDLE;
			s.sync2 <= `SYNC_IDLE;
			s.dcr <= `DCR_RESET;
			s.mode <= `MODE_RESET;
			s.err_en_n <= `ERRN_RESET;
			s.irq_mask <= `MASK_RESET;
			s.strobe_n <= 1'b1;
			s.autofd_n <= 1'b1;
			s.init_n <= 1'b1;
			s.selin_n <= 1'b1;
			s.fault_q <= 1'b1;
			s.ack_q <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign parallel_data_lines_out = s.pd_o;
	assign parallel_data_lines_oe = s.pd_en;
	assign host_clock_strobe_n = s.strobe_n;
	assign host_handshake_line_n = s.autofd_n;
	assign direction_request_line_n = s.init_n;
	assign select_in_line_n = s.selin_n;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence fwd_byte_ready;
		s.link == L_IDLE && link_mode && fwd && !fifo_empty && !busy_s
			&& !reg_wr;
	endsequence

	sequence rev_capture;
		s.link == L_REV_WAIT && s.mode == `MODE_ECP && !fwd && !ack_n_s
			&& !reg_wr;
	endsequence

	sequence run_data_taken;
		rev_capture ##0 (busy_s && s.run_pending);
	endsequence

	auto_strobe_a: assert property (
		fwd_byte_ready |-> ##[1:4] !host_clock_strobe_n)
		else $error("queued byte never strobed out");

	strobe_hold_a: assert property (
		(s.link == L_STROBE && !busy_s && !reg_wr) |=> !host_clock_strobe_n)
		else $error("strobe released before peripheral busy");

	busy_wait_a: assert property (
		(s.link == L_IDLE && busy_s) |=> s.link != L_SETUP)
		else $error("byte started while peripheral busy");

	fifo_bound_a: assert property (
		s.count <= (PTR_W+1)'(DEPTH))
		else $error("fifo count exceeds depth");

	status_low_a: assert property (
		(reg_rd && reg_addr == `OFS_DSR) |=> reg_rdata[2:0] == 3'h0
			&& reg_rdata[7] == !$past(busy_s))
		else $error("status read wrong");

	word_width_a: assert property (
		(reg_rd && reg_addr == `OFS_FIFO && s.mode == `MODE_CONFIG)
			|=> reg_rdata == `CFGA_VALUE)
		else $error("config a read wrong");

	fifo_flags_a: assert property (
		(reg_rd && reg_addr == `OFS_ECR) |=> reg_rdata[1] == $past(fifo_full)
			&& reg_rdata[0] == $past(fifo_empty))
		else $error("fifo flags do not match occupancy");

	cfgb_report_a: assert property (
		(reg_rd && reg_addr == `OFS_CFGB) |=> reg_rdata[5:0]
			== {$past(irq_select), $past(dma_select)})
		else $error("config b irq or dma wrong");

	rle_expand_a: assert property (
		run_data_taken |=> s.rep_left == {1'b0, $past(s.run_count)} + 8'h01
			##1 (s.rep_left == $past(s.rep_left) - 8'h01 || $past(fifo_full)))
		else $error("run length not expanded");

	rev_tag_a: assert property (
		(rev_capture ##0 (busy_s ? !s.run_pending : pd_s[`ADDR_FLAG_BIT]))
			|=> s.mem[$past(s.wr_ptr)][`TAG_BIT] == !$past(busy_s))
		else $error("reverse byte tag wrong");

	addr_tag_a: assert property (
		(reg_wr && reg_addr == `OFS_DATA && s.mode == `MODE_ECP && fwd
			&& !fifo_full) |=> s.mem[$past(s.wr_ptr)]
			== {1'b1, $past(reg_wdata)})
		else $error("address byte not queued tagged");

	dma_dir_a: assert property (
		(s.dma_en && s.mode == `MODE_ECP && !fwd && !fifo_empty) |-> dma_req)
		else $error("reverse dma request missing");

	ctl_any_mode_a: assert property (
		(reg_wr && reg_addr == `OFS_DCR) |=> s.dcr == $past(reg_wdata[5:0]))
		else $error("control register write lost");

endmodule : ecp_port

/* File: ecp_periph_model.sv */
`timescale 1ns/10ps

module ecp_periph_model (
	input wire logic clk_sys,
	input wire logic [7:0] pd_from_host,
	input wire logic strobe_n,
	input wire logic autofd_n,
	input wire logic init_n,
	input wire logic [2:0] lat,
	output logic [7:0] pd_to_host,
	output logic clk_n,
	output logic busy
);
	// got holds {autofd level, byte}; tx holds {handshake level, byte}
	logic [8:0] got[$];
	logic [8:0] tx[$];
	logic [8:0] b;
	logic active;

	initial begin
		pd_to_host = 8'h00;
		clk_n = 1'b1;
		busy = 1'b0;
		active = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (init_n && !strobe_n) begin
				got.push_back({autofd_n, pd_from_host});
				busy <= 1'b1;
				while (!strobe_n) begin
					@(posedge clk_sys);
				end
				repeat (lat) @(posedge clk_sys);
				busy <= 1'b0;
			end else if (!init_n && !autofd_n && tx.size() > 0) begin
				b = tx.pop_front();
				active = 1'b1;
				pd_to_host <= b[7:0];
				busy <= b[8];
				repeat (lat) @(posedge clk_sys);
				clk_n <= 1'b0;
				while (!autofd_n) begin
					@(posedge clk_sys);
				end
				clk_n <= 1'b1;
				busy <= 1'b0;
				// released lines must not keep showing the last byte
				pd_to_host <= ~b[7:0];
				active = 1'b0;
			end
		end
	end
endmodule : ecp_periph_model

/* File: extended_capabilities_parallel_port_tb_top.sv */
`timescale 1ns/10ps

module extended_capabilities_parallel_port_tb_top;
	logic clk_sys, rst_n, reg_wr, reg_rd, dma_req, irq;
	logic [10:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pd_out, pd_m, v, d;
	logic [2:0] irq_sel, dma_sel, lat;
	logic pd_oe, strobe_n, autofd_n, init_n, pclk_n, busy, flt_n, pe, sel;
	logic selin_n;
	logic [8:0] exp_q[$];
	logic [7:0] tv[16];
	int err_count, num_checks, i;
	wire [7:0] pd_in = pd_oe ? pd_out : pd_m;

	ecp_port ecp_port_i (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq_select(irq_sel),
		.dma_select(dma_sel),
		.dma_req(dma_req),
		.irq(irq),
		.parallel_data_lines_in(pd_in),
		.parallel_data_lines_out(pd_out),
		.parallel_data_lines_oe(pd_oe),
		.host_clock_strobe_n(strobe_n),
		.host_handshake_line_n(autofd_n),
		.direction_request_line_n(init_n),
		.select_in_line_n(selin_n),
		.periph_clock_line_n(pclk_n),
		.periph_handshake(busy),
		.periph_fault_line_n(flt_n),
		.paper_error_line(pe),
		.select_line(sel)
	);

	ecp_periph_model ecp_periph_model_i (
		.clk_sys(clk_sys),
		.pd_from_host(pd_in),
		.strobe_n(strobe_n),
		.autofd_n(autofd_n),
		.init_n(init_n),
		.lat(lat),
		.pd_to_host(pd_m),
		.clk_n(pclk_n),
		.busy(busy)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	function automatic logic [7:0] dsr_exp();
		return {~busy, pclk_n, pe, sel, flt_n, 3'h0};
	endfunction : dsr_exp

	function automatic bit ready(input int k);
		if (k == 0)
			return ecp_periph_model_i.tx.size() == 0 && pclk_n === 1'b1
				&& autofd_n === 1'b0 && ecp_periph_model_i.active === 1'b0;
		return ecp_periph_model_i.got.size() >= k;
	endfunction : ready

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// bounded wait: a stuck link ends the run instead of hanging
	task automatic wait_until(input int k);
		for (int j = 0; j < 3000 && !ready(k); j++) @(posedge clk_sys);
		chk("link done", 9'h001, {8'h00, ready(k)});
		if (!ready(k))
			wrap_up();
	endtask : wait_until

	// trailing edge keeps back-to-back strobes from colliding
	task automatic wr(input logic [10:0] a, input logic [7:0] dv);
		reg_addr <= a;
		reg_wdata <= dv;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [10:0] a, output logic [7:0] dv);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		// read data stand only until the next edge
		@(negedge clk_sys);
		dv = reg_rdata;
		@(posedge clk_sys);
	endtask : rd

	task automatic rc(input logic [10:0] a, input logic [7:0] e);
		logic [7:0] dv;
		rd(a, dv);
		chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, dv});
	endtask : rc

	initial begin
		rst_n = 1'b0;
		reg_addr = 11'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lat = 3'h1;
		err_count = 0;
		num_checks = 0;
		void'($urandom(32'hABD5));
		irq_sel = 3'($urandom());
		dma_sel = 3'($urandom());
		{flt_n, pe, sel} = 3'($urandom());
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rc(11'h402, 8'h11);
		rc(11'h002, 8'h04);
		rc(11'h005, 8'h00);
		wr(11'h402, 8'hF0);
		rc(11'h401, {2'h0, irq_sel, dma_sel});
		rc(11'h400, 8'h10);
		// test view: 17th byte must be dropped
		wr(11'h402, 8'hD0);
		for (i = 0; i < 17; i++) begin
			v = 8'($urandom());
			if (i < 16)
				tv[i] = v;
			wr(11'h400, v);
		end
		rc(11'h402, 8'hD2);
		rc(11'h002, 8'h04);
		rc(11'h001, dsr_exp());
		for (i = 0; i < 16; i++) rc(11'h400, tv[i]);
		rc(11'h402, 8'hD1);
		// service event masked, then unmasked
		wr(11'h402, 8'h70);
		@(posedge clk_sys);
		chk("irq", 9'h000, {8'h00, irq});
		rc(11'h403, 8'h02);
		wr(11'h404, 8'h02);
		wr(11'h402, 8'h10);
		wr(11'h402, 8'h70);
		@(posedge clk_sys);
		chk("irq", 9'h001, {8'h00, irq});
		rc(11'h403, 8'h02);
		chk("irq", 9'h000, {8'h00, irq});
		wr(11'h402, 8'h78);
		chk("dma_req", 9'h001, {8'h00, dma_req});
		wr(11'h402, 8'h70);
		rd(11'h403, d);
		wr(11'h404, 8'h00);
		// compat bytes, then address, count and data bytes
		wr(11'h402, 8'h50);
		for (i = 0; i < 3; i++) begin
			v = 8'($urandom());
			lat <= 3'($urandom_range(1, 4));
			exp_q.push_back({1'b1, v});
			wr(11'h400, v);
		end
		wait_until(3);
		wr(11'h402, 8'h70);
		for (i = 0; i < 3; i++) begin
			v = 8'($urandom());
			if (i < 2)
				v[7] = (i == 0);
			exp_q.push_back({i == 2, v});
			wr(i == 2 ? 11'h400 : 11'h000, v);
		end
		wait_until(6);
		for (i = 0; i < 6; i++) begin
			chk("fwd byte", exp_q[i], ecp_periph_model_i.got[i]);
		end
		// reverse: run count 2, data, channel address, data
		wr(11'h002, 8'h30);
		chk("init_n", 9'h000, {8'h00, init_n});
		chk("pd_oe", 9'h000, {8'h00, pd_oe});
		chk("select_in", 9'h001, {8'h00, selin_n});
		v = 8'($urandom());
		ecp_periph_model_i.tx = '{9'h002, 9'h1AB, 9'h085, {1'b1, v}};
		wait_until(0);
		for (i = 0; i < 3; i++) rc(11'h400, 8'hAB);
		rc(11'h400, 8'h85);
		rc(11'h400, v);
		rd(11'h402, d);
		chk("empty", 9'h001, {8'h00, d[0]});
		rc(11'h403, 8'h06);
		wrap_up();
	end
endmodule : extended_capabilities_parallel_port_tb_top
